/* File: design/msc_conv_ctl.sv */
// Start and stop control of one converter channel.
// Assumes the converter reports conversion end and its mode as levels.
`timescale 1ns/1ps
`default_nettype none
module msc_conv_ctl
  import msc_pkg::*;
(
  input  wire logic CLK_IN,
  input  wire logic SYS_RST_IN,
  input  wire logic go_wr_in,
  input  wire logic halt_wr_in,
  input  wire logic single_shot_in,
  input  wire logic conv_done_in,
  output logic      go_out,
  output logic      halt_out,
  output logic      halt_pending_out
);

  logic halt_ff;
  logic nxt_halt;
  logic go_ff;

  // Start wins; a stop in single shot is dropped
  assign nxt_halt = go_wr_in                         ? 1'b0 :
                    (halt_wr_in && !single_shot_in)  ? 1'b1 :
                    conv_done_in                     ? 1'b0 :
                    halt_ff;

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      halt_ff <= 1'b0;
      go_ff   <= 1'b0;
    end else begin
      halt_ff <= nxt_halt;
      go_ff   <= go_wr_in;
    end
  end

  assign go_out           = go_ff;
  assign halt_out         = halt_ff && conv_done_in;
  assign halt_pending_out = halt_ff;

endmodule : msc_conv_ctl
`default_nettype wire

/* File: design/msc_pkg.sv */
// Constants, field layout and carrier types of the monitor status and
// conversion control register bank.
// Assumes a single 20 MHz clock and a synchronous active-high reset.
package msc_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_FAULT_STATUS = 8'h06;
  localparam logic [7:0] OFS_LEVEL_RB     = 8'h07;
  localparam logic [7:0] OFS_SIDE_RB      = 8'h08;
  localparam logic [7:0] OFS_STROBES      = 8'h09;

  // ==========================================================
  // Reset values
  localparam logic [15:0] RST_FAULT_STATUS = 16'h000f;
  localparam logic [15:0] RST_LEVEL_RB     = 16'h0000;
  localparam logic [15:0] RST_SIDE_RB      = 16'h0000;
  localparam logic [15:0] RST_STROBES      = 16'h0000;

  // ==========================================================
  // Fault status bit positions
  localparam int unsigned BIT_CHAN_A_HIGH = 3;
  localparam int unsigned BIT_CHAN_A_LOW  = 2;
  localparam int unsigned BIT_CHAN_B_HIGH = 1;
  localparam int unsigned BIT_CHAN_B_LOW  = 0;
  localparam logic [15:0] MASK_FAULT      = 16'h000f;

  // ==========================================================
  // Readback field positions (low bit of each pair)
  localparam int unsigned POS_PIN0   = 0;
  localparam int unsigned N_PINS     = 5;
  localparam int unsigned POS_SIDE_A = 8;
  localparam int unsigned POS_SIDE_B = 0;

  // ==========================================================
  // Conversion strobe bit positions
  localparam int unsigned BIT_PA_GO    = 14;
  localparam int unsigned BIT_PB_GO    = 12;
  localparam int unsigned BIT_PA_HALT  = 10;
  localparam int unsigned BIT_PB_HALT  = 8;
  localparam int unsigned BIT_MA_GO    = 6;
  localparam int unsigned BIT_MB_GO    = 4;
  localparam int unsigned BIT_MA_HALT  = 2;
  localparam int unsigned BIT_MB_HALT  = 0;

  // ==========================================================
  // Level codes
  typedef enum logic [1:0] {
    LVL_LOW       = 2'h0,
    LVL_WEAK_LOW  = 2'h1,
    LVL_WEAK_HIGH = 2'h2,
    LVL_HIGH      = 2'h3
  } msc_level_e;

  // Register access request from the serial command decoder
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } msc_req_s;

  // Trip events from the comparators, one-cycle pulses
  typedef struct packed {
    logic a_high;
    logic a_low;
    logic b_high;
    logic b_low;
  } msc_trip_s;

  // Strobes toward one converter
  typedef struct packed {
    logic go;
    logic halt;
  } msc_conv_cmd_s;

endpackage : msc_pkg

/* File: design/msc_regs.sv */
// Register bank: overcurrent trip status, GPIO level readback and
// conversion start/stop strobes.
// Assumes the serial command decoder hands in one-cycle register
// accesses and samples read data one cycle after the request.
`timescale 1ns/1ps
`default_nettype none
module msc_regs
  import msc_pkg::*;
#(
  parameter int unsigned N_CONV = 4
) (
  input  wire logic                   CLK_IN,
  input  wire logic                   SYS_RST_IN,
  input  wire msc_req_s               REQ_IN,
  output logic [DATA_W-1:0]           RDATA_OUT,
  output logic                        RVALID_OUT,
  input  wire msc_trip_s              TRIP_IN,
  input  wire logic [2*N_PINS-1:0]    PIN_LEVEL_IN,
  input  wire logic [7:0]             SIDE_LEVEL_IN,
  input  wire logic [N_CONV-1:0]      SINGLE_SHOT_IN,
  input  wire logic [N_CONV-1:0]      CONV_DONE_IN,
  output msc_conv_cmd_s [N_CONV-1:0]  CONV_CMD_OUT,
  output logic [N_CONV-1:0]           HALT_PENDING_OUT,
  output logic [3:0]                  TRIP_FLAGS_OUT
);

  // ==========================================================
  // Address decode
  function automatic logic hit(input msc_req_s r, input logic [7:0] ofs);
    hit = (r.addr == ofs);
  endfunction : hit

  wire logic wr_fault   = REQ_IN.wr && hit(REQ_IN, OFS_FAULT_STATUS);
  wire logic wr_strobes = REQ_IN.wr && hit(REQ_IN, OFS_STROBES);

  // ==========================================================
  // Trip flags, active low; a new trip beats a clearing write
  logic [3:0] flags_ff;
  logic [3:0] nxt_flags;
  logic [3:0] trip_vec;
  logic [3:0] clr_vec;

  assign trip_vec = {TRIP_IN.a_high, TRIP_IN.a_low,
                     TRIP_IN.b_high, TRIP_IN.b_low};
  // Only bits 3:0 are writable
  assign clr_vec   = wr_fault ? REQ_IN.wdata[3:0] : 4'h0;
  assign nxt_flags = (flags_ff | clr_vec) & ~trip_vec;

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      flags_ff <= RST_FAULT_STATUS[3:0];
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign TRIP_FLAGS_OUT = flags_ff;

  // ==========================================================
  // Level readback; codes follow the pin regardless of direction
  logic [DATA_W-1:0] level_rb;
  logic [DATA_W-1:0] side_rb;

  assign level_rb = {6'h00, PIN_LEVEL_IN};
  assign side_rb  = {4'h0, SIDE_LEVEL_IN[7:4], 4'h0, SIDE_LEVEL_IN[3:0]};

  // ==========================================================
  // Conversion strobes: order precise A, precise B, mux A, mux B
  localparam int unsigned GO_BIT   [4] = '{BIT_PA_GO, BIT_PB_GO,
                                           BIT_MA_GO, BIT_MB_GO};
  localparam int unsigned HALT_BIT [4] = '{BIT_PA_HALT, BIT_PB_HALT,
                                           BIT_MA_HALT, BIT_MB_HALT};
  logic [N_CONV-1:0] halt_pend;
  logic [DATA_W-1:0] strobe_rb;

  genvar g;
  generate
    for (g = 0; g < N_CONV; g++) begin : g_conv
      msc_conv_ctl u_ctl (
        .CLK_IN           (CLK_IN),
        .SYS_RST_IN       (SYS_RST_IN),
        .go_wr_in         (wr_strobes && REQ_IN.wdata[GO_BIT[g]]),
        .halt_wr_in       (wr_strobes && REQ_IN.wdata[HALT_BIT[g]]),
        .single_shot_in   (SINGLE_SHOT_IN[g]),
        .conv_done_in     (CONV_DONE_IN[g]),
        .go_out           (CONV_CMD_OUT[g].go),
        .halt_out         (CONV_CMD_OUT[g].halt),
        .halt_pending_out (halt_pend[g])
      );
    end
  endgenerate

  assign HALT_PENDING_OUT = halt_pend;

  // Start bits read 0; stop bits show pending; odd bits 0
  always_comb begin
    strobe_rb = RST_STROBES;
    for (int i = 0; i < N_CONV; i++) begin
      strobe_rb[HALT_BIT[i]] = halt_pend[i];
    end
  end

  // ==========================================================
  // Read path, registered; unmapped offsets read zero
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic              rvalid_ff;

  assign nxt_rdata =
      hit(REQ_IN, OFS_FAULT_STATUS) ? {12'h000, flags_ff} :
      hit(REQ_IN, OFS_LEVEL_RB)     ? level_rb :
      hit(REQ_IN, OFS_SIDE_RB)      ? side_rb :
      hit(REQ_IN, OFS_STROBES)      ? strobe_rb :
                                      16'h0000;

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      rdata_ff  <= 16'h0000;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= REQ_IN.rd;
      if (REQ_IN.rd) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign RDATA_OUT  = rdata_ff;
  assign RVALID_OUT = rvalid_ff;

endmodule : msc_regs
`default_nettype wire

/* File: sim/msc_host.sv */
// Host model issuing one-cycle register accesses.
// Assumes read data comes with a valid pulse one cycle later.
`timescale 1ns/1ps
`default_nettype none
module msc_host
  import msc_pkg::*;
(
  input  wire logic        CLK_IN,
  output var msc_req_s     REQ_OUT,
  input  wire logic [15:0] RDATA_IN,
  input  wire logic        RVALID_IN
);
  initial REQ_OUT = '0;
  // Released bus shows inverted values, never the last ones
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [15:0] d, output logic [15:0] q);
    @(posedge CLK_IN);
    #1;
    REQ_OUT = '{w, !w, a, d};
    @(posedge CLK_IN);
    #1;
    REQ_OUT = '{1'b0, 1'b0, ~a, ~d};
    q = RVALID_IN ? RDATA_IN : 16'hxxxx;
  endtask : acc
endmodule : msc_host
`default_nettype wire

/* File: sim/msc_regs_chk.sv */
// Port checker for the register bank, attached by bind.
// Assumes the single clock domain of msc_regs.
`timescale 1ns/1ps
`default_nettype none
module msc_regs_chk
  import msc_pkg::*;
#(
  parameter int unsigned N_CONV = 4
) (
  input wire logic                       CLK_IN,
  input wire logic                       SYS_RST_IN,
  input wire msc_req_s                   REQ_IN,
  input wire logic [DATA_W-1:0]          RDATA_OUT,
  input wire logic                       RVALID_OUT,
  input wire msc_trip_s                  TRIP_IN,
  input wire logic [2*N_PINS-1:0]        PIN_LEVEL_IN,
  input wire logic [7:0]                 SIDE_LEVEL_IN,
  input wire logic [N_CONV-1:0]          SINGLE_SHOT_IN,
  input wire logic [N_CONV-1:0]          CONV_DONE_IN,
  input wire msc_conv_cmd_s [N_CONV-1:0] CONV_CMD_OUT,
  input wire logic [N_CONV-1:0]          HALT_PENDING_OUT,
  input wire logic [3:0]                 TRIP_FLAGS_OUT
);
  wire logic wr_st = REQ_IN.wr && REQ_IN.addr == OFS_FAULT_STATUS;
  wire logic wr_cv = REQ_IN.wr && REQ_IN.addr == OFS_STROBES;
  wire logic rd_lv = REQ_IN.rd && REQ_IN.addr == OFS_LEVEL_RB;
  wire logic rd_cv = REQ_IN.rd && REQ_IN.addr == OFS_STROBES;
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  // ====================
  // Properties
  a_trip_a_high:
    assert property (TRIP_IN.a_high |=> !TRIP_FLAGS_OUT[3]) else $error("trip");
  a_trip_a_low:
    assert property (TRIP_IN.a_low |=> !TRIP_FLAGS_OUT[2]) else $error("trip");
  a_trip_b_high:
    assert property (TRIP_IN.b_high |=> !TRIP_FLAGS_OUT[1]) else $error("trip");
  a_trip_b_low:
    assert property (TRIP_IN.b_low |=> !TRIP_FLAGS_OUT[0]) else $error("trip");
  a_flag_clear:
    assert property (wr_st && REQ_IN.wdata[3] && !TRIP_IN.a_high
      |=> TRIP_FLAGS_OUT[3]) else $error("flag not cleared");
  a_level_read:
    assert property (rd_lv |=> RDATA_OUT == {6'h0, $past(PIN_LEVEL_IN)})
      else $error("level readback");
  a_strobe_read:
    assert property (rd_cv |=> (RDATA_OUT & 16'hfafa) == 16'h0)
      else $error("strobe readback");
  a_go_pulse:
    assert property (wr_cv && REQ_IN.wdata[BIT_PA_GO] |=> CONV_CMD_OUT[0].go)
      else $error("no start");
  a_halt_on_done:
    assert property (HALT_PENDING_OUT[0] && CONV_DONE_IN[0] && !wr_cv
      |-> CONV_CMD_OUT[0].halt ##1 !HALT_PENDING_OUT[0]) else $error("stop");
  a_go_single:
    assert property (!(wr_cv && REQ_IN.wdata[BIT_PA_GO])
      |=> !CONV_CMD_OUT[0].go) else $error("stray start");
  a_reset_flags:
    assert property ($fell(SYS_RST_IN)
      |-> TRIP_FLAGS_OUT == 4'hf && HALT_PENDING_OUT == '0)
      else $error("reset state");
endmodule : msc_regs_chk
bind msc_regs msc_regs_chk #(.N_CONV(N_CONV)) msc_regs_chk_inst (.*);
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench for the register bank.
// Assumes msc_host as the only register requester.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import msc_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1;
  logic [3:0] trip = '0, ss = '0, done = '0, pend, flags;
  logic [9:0] pins = '0;
  logic [7:0] side = '0;
  logic [15:0] rdata, q;
  logic rvalid;
  msc_req_s req;
  msc_conv_cmd_s [3:0] cmd;
  int err_count = 0, checked = 0;
  always #25 clk = ~clk;
  msc_host msc_host_inst (.CLK_IN(clk), .REQ_OUT(req), .RDATA_IN(rdata),
    .RVALID_IN(rvalid));
  msc_regs msc_regs_inst (.CLK_IN(clk), .SYS_RST_IN(rst), .REQ_IN(req),
    .RDATA_OUT(rdata), .RVALID_OUT(rvalid), .TRIP_IN(trip),
    .PIN_LEVEL_IN(pins), .SIDE_LEVEL_IN(side), .SINGLE_SHOT_IN(ss),
    .CONV_DONE_IN(done), .CONV_CMD_OUT(cmd), .HALT_PENDING_OUT(pend),
    .TRIP_FLAGS_OUT(flags));
  // ====================
  // Helpers
  task automatic summarize();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    msc_host_inst.acc(1'b1, a, d, q);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    msc_host_inst.acc(1'b0, a, 16'h0, q);
    chk(q, exp);
  endtask : rchk
  task automatic trip_pulse(input logic [3:0] v);
    @(posedge clk);
    #1;
    trip = v;
    @(posedge clk);
    #1;
    trip = '0;
  endtask : trip_pulse
  function automatic logic [15:0] side_exp(input logic [7:0] s);
    return {4'h0, s[7:4], 4'h0, s[3:0]};
  endfunction : side_exp
  initial begin
    #100000;
    err_count++;
    summarize();
  end
  initial begin
    int gb, hb;
    void'($urandom(16));
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    rchk(OFS_FAULT_STATUS, RST_FAULT_STATUS);
    rchk(OFS_STROBES, RST_STROBES);
    rchk(8'h0a, 16'h0);
    for (int j = 0; j < 6; j++) begin
      pins = j == 0 ? 10'h3ff : 10'($urandom);
      side = j == 0 ? 8'hff : 8'($urandom);
      wr(OFS_LEVEL_RB, 16'hffff);
      rchk(OFS_LEVEL_RB, {6'h0, pins});
      rchk(OFS_SIDE_RB, side_exp(side));
    end
    for (int i = 0; i < 4; i++) begin
      trip_pulse(4'(1 << i));
      rchk(OFS_FAULT_STATUS, 16'h000f ^ 16'(1 << i));
      wr(OFS_FAULT_STATUS, 16'hffff);
      rchk(OFS_FAULT_STATUS, 16'h000f);
    end
    // Event and clearing write in one cycle: event must win
    fork
      wr(OFS_FAULT_STATUS, 16'h0008);
      trip_pulse(4'h8);
    join
    rchk(OFS_FAULT_STATUS, 16'h0007);
    // Mid-run reset with a trip flag down and a stop pending
    wr(OFS_STROBES, 16'(1 << BIT_PA_HALT));
    @(posedge clk);
    #1;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    rchk(OFS_FAULT_STATUS, RST_FAULT_STATUS);
    rchk(OFS_STROBES, RST_STROBES);
    for (int i = 0; i < 4; i++) begin
      gb = i < 2 ? 14 - 2 * i : 10 - 2 * i;
      hb = gb - 4;
      wr(OFS_STROBES, 16'(1 << gb));
      chk(16'(cmd[i].go), 16'h1);
      rchk(OFS_STROBES, 16'h0);
      wr(OFS_STROBES, 16'haaaa | 16'(1 << hb));
      rchk(OFS_STROBES, 16'(1 << hb));
      @(posedge clk);
      #1;
      done[i] = 1'b1;
      #1;
      chk(16'(cmd[i].halt), 16'h1);
      @(posedge clk);
      #1;
      done[i] = 1'b0;
      chk(16'(pend[i]), 16'h0);
      wr(OFS_STROBES, 16'(1 << hb));
      wr(OFS_STROBES, 16'(1 << gb) | 16'(1 << hb));
      chk(16'({cmd[i].go, pend[i]}), 16'h2);
      ss[i] = 1'b1;
      wr(OFS_STROBES, 16'(1 << hb));
      chk(16'(pend[i]), 16'h0);
    end
    summarize();
  end
endmodule : tb_top
`default_nettype wire
